// ### hdl/sibt_pkg.sv
// Constants for the interval counters and the countdown timer.
// Assumes a 100 MHz system clock and I/O port accesses from the host.
// Notes on behaviour
// - Three independent interval counters in one unit, each output serving a function.
// - Counter zero output drives the system tick interrupt line.
// - Counter one output is refresh request; counter two output is speaker tone.
// - All interval counters clock from the divided crystal reference.
// - In rate and square-wave modes a written count loads on the next counter-clock tick.
// - Square wave: output high, decrement by two, toggle and reload at count two or one.
// - Square-wave period equals counter period times initial count, rounded up to even.
// - Rate generator: output low for one period at count one, then reload.
// - Tone is clock over count rounded up to even; software enables speaker via control port.
// - Counter two gate from control port bit; other gates tied high.
// - One-shot on counter two starts on gate rising edge; edges may be missed.
// - Countdown timer decrements once per eighth bus clock.
// - Base register enable gates access; counting continues when disabled.
// - Countdown timer address decoded from the programmed base address.
// - 16 or 32-bit access; upper half ignored on write, zero on read.
// - Write starts countdown; decrement to zero then hold zero.
// - Reads return current value; rewrite accepted at any time.
// - Prescaler phase not reset on write; first decrement may come early.
package sibt_pkg;
	// ----------------------------------------
	// I/O ports
	// ----------------------------------------
	localparam logic [15:0] PORT_CNT0     = 16'h0040;
	localparam logic [15:0] PORT_CNT1     = 16'h0041;
	localparam logic [15:0] PORT_CNT2     = 16'h0042;
	localparam logic [15:0] PORT_CTRL     = 16'h0043;
	localparam logic [15:0] PORT_SYSCTL   = 16'h0061;
	localparam logic [15:0] PORT_BASE     = 16'h0078;
	localparam int          BASE_EN_BIT   = 0;
	localparam int          SYS_GATE_BIT  = 0;
	localparam int          SYS_SPK_BIT   = 1;
	localparam int          SYS_OUT2_BIT  = 5;
	// ----------------------------------------
	// Modes and timing
	// ----------------------------------------
	localparam logic [2:0]  MODE_ONESHOT  = 3'h1;
	localparam logic [2:0]  MODE_RATE     = 3'h2;
	localparam logic [2:0]  MODE_SQUARE   = 3'h3;
	localparam int          CLK_MHZ_X1000 = 100000;
	localparam int          XTAL_KHZ      = 1193;
	localparam int          XTAL_DIV      = CLK_MHZ_X1000 / XTAL_KHZ;
	localparam logic [6:0]  XTAL_DIV_M1   = 7'(XTAL_DIV - 1);
	localparam logic [2:0]  BUS_DIV_M1    = 3'h7;
endpackage

// ### hdl/sibt_ctr_if.sv
// Carrier from the port decoder to one interval counter.
// Assumes a single system clock.
`timescale 1ns/1ps
interface sibt_ctr_if;
	logic       wr_cnt;
	logic       wr_mode;
	logic [7:0] wdata;
	logic       gate;
	logic       tick;
	logic       out;
	logic [15:0] count;
	modport ctl (output wr_cnt, output wr_mode, output wdata, output gate, output tick,
		input out, input count);
	modport ctr (input wr_cnt, input wr_mode, input wdata, input gate, input tick,
		output out, output count);
endinterface

// ### hdl/sibt_counter.sv
// One interval counter: one-shot, rate and square-wave modes.
// Assumes tick is a one-cycle pulse at the counter-clock rate.
`timescale 1ns/1ps
module sibt_counter (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	sibt_ctr_if.ctr  bus
);
	typedef struct packed {
		logic [2:0]  mode;
		logic        lsb_done;
		logic [15:0] init;
		logic        pend;
		logic [15:0] cnt;
		logic        out;
		logic        run;
		logic        gate_d;
	} sibt_cst_s;
	sibt_cst_s st;
	sibt_cst_s next_st;

	always_comb begin
		next_st = st;
		if (bus.wr_mode) begin
			next_st.mode = bus.wdata[3:1];
			next_st.lsb_done = 1'b0;
			next_st.out = 1'b1;
			next_st.run = 1'b0;
		end else if (bus.wr_cnt) begin
			if (!st.lsb_done) begin
				next_st.init[7:0] = bus.wdata;
				next_st.lsb_done = 1'b1;
			end else begin
				next_st.init[15:8] = bus.wdata;
				next_st.lsb_done = 1'b0;
				next_st.pend = 1'b1;
			end
		end
		if (bus.tick) begin
			next_st.gate_d = bus.gate;
			if (st.pend && st.mode != sibt_pkg::MODE_ONESHOT) begin
				// Load on the first counter tick after the write
				next_st.cnt = st.init;
				// A second count written on the load edge stays pending
				next_st.pend = bus.wr_cnt && st.lsb_done;
				next_st.run = 1'b1;
				next_st.out = 1'b1;
			end else if (st.mode == sibt_pkg::MODE_ONESHOT) begin
				if (bus.gate && !st.gate_d) begin
					next_st.cnt = st.init;
					next_st.pend = 1'b0;
					next_st.run = 1'b1;
					next_st.out = 1'b0;
				end else if (st.run) begin
					next_st.cnt = st.cnt - 16'h0001;
					if (st.cnt == 16'h0001) begin
						next_st.out = 1'b1;
						next_st.run = 1'b0;
					end
				end
			end else if (st.run && bus.gate) begin
				if (st.mode == sibt_pkg::MODE_RATE) begin
					// Low for exactly one period at count one
					next_st.out = (st.cnt != 16'h0002);
					next_st.cnt = (st.cnt == 16'h0001) ? st.init : st.cnt - 16'h0001;
				end else begin
					// Two-step decrement; odd counts gain half a period per half
					if (st.cnt <= 16'h0002) begin
						next_st.cnt = st.init;
						next_st.out = ~st.out;
					end else begin
						next_st.cnt = st.cnt - 16'h0002;
					end
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st <= '{mode: sibt_pkg::MODE_SQUARE, out: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign bus.out = st.out;
	assign bus.count = st.cnt;

	gate_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		bus.tick && st.mode == sibt_pkg::MODE_ONESHOT && bus.gate && !st.gate_d
		|=> st.run && !st.out) else $error("one-shot did not start on gate edge");
	rate_low_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		bus.tick && st.run && bus.gate && !st.pend && st.mode == sibt_pkg::MODE_RATE
		&& st.cnt == 16'h0001 |=> st.cnt == $past(st.init) && st.out)
		else $error("rate counter did not reload");
	load_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		bus.wr_cnt && st.lsb_done && !bus.tick |=> st.pend)
		else $error("written count was not held for a period");
endmodule

// ### hdl/sibt_top.sv
// Interval counters and relocatable countdown timer behind I/O ports.
// Assumes one host I/O access per strobe, on the system clock.
`timescale 1ns/1ps
module sibt_top (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	input  wire logic        i_crystal_reference_clock,
	input  wire logic        i_expansion_bus_clock,
	input  wire logic        i_io_wr,
	input  wire logic        i_io_rd,
	input  wire logic [15:0] i_io_addr,
	input  wire logic [3:0]  i_io_be,
	input  wire logic [31:0] i_io_wdata,
	output logic      [31:0] o_io_rdata,
	output logic             o_io_hit,
	output logic             o_system_tick_interrupt,
	output logic             o_refresh_request,
	output logic             o_speaker_tone
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]  xtal_sync;
		logic        xtal_lvl;
		logic [2:0]  bus_sync;
		logic        bus_lvl;
		logic [6:0]  xtal_div;
		logic [2:0]  bus_div;
		logic [7:0]  sysctl;
		logic [15:0] base;
		logic [15:0] bt_cnt;
		logic [31:0] rdata;
		logic        hit;
	} sibt_st_s;
	sibt_st_s st;
	sibt_st_s next_st;

	sibt_ctr_if ctr_if[3] ();
	logic [1:0] sel_ctr;
	logic       ctr_tick;
	logic       bus_tick;
	logic       bt_hit;
	logic       xtal_rise;
	logic       bus_rise;

	function automatic logic is_port(input logic [15:0] a, input logic [15:0] p);
		return a == p;
	endfunction

	// ----------------------------------------
	// Clock references
	// ----------------------------------------
	// Edge counts only once the second and third stages agree
	assign xtal_rise = (st.xtal_sync[2] == st.xtal_sync[1]) && st.xtal_sync[2] && !st.xtal_lvl;
	assign bus_rise = (st.bus_sync[2] == st.bus_sync[1]) && st.bus_sync[2] && !st.bus_lvl;
	// Crystal edges set the counter clock; divider is the local stand-in
	assign ctr_tick = xtal_rise && st.xtal_div == '0;
	assign bus_tick = bus_rise && st.bus_div == sibt_pkg::BUS_DIV_M1;
	// Countdown timer port follows the base register
	assign bt_hit = st.base[sibt_pkg::BASE_EN_BIT]
		&& (i_io_addr[15:2] == st.base[15:2]);
	assign sel_ctr = i_io_addr[1:0];

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_ctr
			assign ctr_if[g].wr_cnt = i_io_wr && is_port(i_io_addr, sibt_pkg::PORT_CNT0 + 16'(g));
			assign ctr_if[g].wr_mode = i_io_wr && is_port(i_io_addr, sibt_pkg::PORT_CTRL)
				&& i_io_wdata[7:6] == 2'(g);
			assign ctr_if[g].wdata = i_io_wdata[7:0];
			assign ctr_if[g].tick = ctr_tick;
			// Only counter two sees a software gate
			assign ctr_if[g].gate = (g == 2) ? st.sysctl[sibt_pkg::SYS_GATE_BIT] : 1'b1;
			sibt_counter u_ctr (
				.i_clk_sys (i_clk_sys),
				.i_reset   (i_reset),
				.bus       (ctr_if[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.xtal_sync = {st.xtal_sync[1:0], i_crystal_reference_clock};
		next_st.bus_sync = {st.bus_sync[1:0], i_expansion_bus_clock};
		if (st.xtal_sync[2] == st.xtal_sync[1]) begin
			next_st.xtal_lvl = st.xtal_sync[2];
		end
		if (st.bus_sync[2] == st.bus_sync[1]) begin
			next_st.bus_lvl = st.bus_sync[2];
		end
		if (xtal_rise) begin
			next_st.xtal_div = (st.xtal_div == '0) ? sibt_pkg::XTAL_DIV_M1
				: st.xtal_div - 7'h01;
		end
		// Free-running; a write never resets the phase
		if (bus_rise) begin
			next_st.bus_div = st.bus_div + 3'h1;
		end
		// Keeps counting regardless of access enable
		if (bus_tick && st.bt_cnt != '0) begin
			next_st.bt_cnt = st.bt_cnt - 16'h0001;
		end
		next_st.hit = 1'b0;
		next_st.rdata = '0;
		if (i_io_wr) begin
			if (bt_hit) begin
				if (&i_io_be[1:0]) begin
					next_st.bt_cnt = i_io_wdata[15:0];
				end
			end else if (is_port(i_io_addr, sibt_pkg::PORT_SYSCTL)) begin
				next_st.sysctl = i_io_wdata[7:0];
			end else if (is_port(i_io_addr, sibt_pkg::PORT_BASE)) begin
				next_st.base = i_io_wdata[15:0];
			end
		end
		if (i_io_rd) begin
			next_st.hit = 1'b1;
			if (bt_hit) begin
				next_st.rdata = {16'h0000, st.bt_cnt};
			end else if (is_port(i_io_addr, sibt_pkg::PORT_SYSCTL)) begin
				next_st.rdata = {24'h000000, st.sysctl};
				next_st.rdata[sibt_pkg::SYS_OUT2_BIT] = ctr_if[2].out;
			end else if (is_port(i_io_addr, sibt_pkg::PORT_BASE)) begin
				next_st.rdata = {16'h0000, st.base};
			end else if (i_io_addr[15:2] == sibt_pkg::PORT_CNT0[15:2] && sel_ctr != 2'h3) begin
				next_st.rdata = {16'h0000, sel_ctr == 2'h0 ? ctr_if[0].count
					: sel_ctr == 2'h1 ? ctr_if[1].count : ctr_if[2].count};
			end else begin
				next_st.hit = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_io_rdata = st.rdata;
	assign o_io_hit = st.hit;
	assign o_system_tick_interrupt = ctr_if[0].out;
	assign o_refresh_request = ctr_if[1].out;
	// Tone reaches the speaker only when software enables it
	assign o_speaker_tone = ctr_if[2].out && st.sysctl[sibt_pkg::SYS_SPK_BIT];

	bt_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		st.bt_cnt == '0 && !(i_io_wr && bt_hit) |=> st.bt_cnt == '0)
		else $error("countdown left zero without a write");
	bt_dec_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		bus_tick && st.bt_cnt != '0 && !i_io_wr |=> st.bt_cnt == $past(st.bt_cnt) - 16'h0001)
		else $error("countdown missed a decrement");
	bt_load_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_io_wr && bt_hit && &i_io_be[1:0] |=> st.bt_cnt == $past(i_io_wdata[15:0]))
		else $error("countdown write not taken whole");
	bt_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_io_rd && bt_hit |=> o_io_hit && o_io_rdata[31:16] == 16'h0000
		&& o_io_rdata[15:0] == $past(st.bt_cnt)) else $error("countdown read wrong");
	bt_off_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!st.base[sibt_pkg::BASE_EN_BIT] |=> st.bt_cnt == $past(st.bt_cnt)
		|| st.bt_cnt == $past(st.bt_cnt) - 16'h0001)
		else $error("closed countdown port took a write");
	spk_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!st.sysctl[sibt_pkg::SYS_SPK_BIT] |-> !o_speaker_tone)
		else $error("speaker driven while disabled");
	bus_div_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		bus_rise |=> st.bus_div == $past(st.bus_div) + 3'h1)
		else $error("prescaler did not advance");
	tick_src_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		ctr_tick |-> xtal_rise) else $error("counter tick without crystal edge");
	bt_start_c: cover property (@(posedge i_clk_sys) i_io_wr && bt_hit);
	bt_zero_c: cover property (@(posedge i_clk_sys) st.bt_cnt == 16'h0001 ##1 st.bt_cnt == '0);
	tick_c: cover property (@(posedge i_clk_sys) $rose(o_system_tick_interrupt));
	spk_c: cover property (@(posedge i_clk_sys) $rose(o_speaker_tone));
endmodule

// ### dv/sibt_host.sv
// Host model: issues I/O port reads and writes to the timer block.
// Assumes the block's system clock; drives just after each rising edge.
`timescale 1ns/1ps
module sibt_host (
	input  wire logic        i_clk_sys,
	input  wire logic [31:0] i_io_rdata,
	input  wire logic        i_io_hit,
	output logic             o_io_wr,
	output logic             o_io_rd,
	output logic      [15:0] o_io_addr,
	output logic      [3:0]  o_io_be,
	output logic      [31:0] o_io_wdata
);
	initial begin
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_io_addr = 16'h0000;
		o_io_be = 4'h0;
		o_io_wdata = 32'h0;
	end
	// ----
	// Bus cycles
	// ----
	// Idle bus shows inverted values, so stale data never looks valid
	task automatic idle_bus();
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_io_addr = ~o_io_addr;
		o_io_wdata = ~o_io_wdata;
	endtask
	// One access per call; interval counter counts go byte by byte, low byte first
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge i_clk_sys);
		#1;
		o_io_addr = a;
		o_io_wdata = d;
		o_io_be = be;
		o_io_wr = 1'b1;
		@(posedge i_clk_sys);
		#1;
		idle_bus();
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic h);
		@(posedge i_clk_sys);
		#1;
		o_io_addr = a;
		o_io_be = 4'hF;
		o_io_rd = 1'b1;
		@(posedge i_clk_sys);
		#1;
		idle_bus();
		d = i_io_rdata;
		h = i_io_hit;
	endtask
endmodule

// ### dv/tb_top.sv
// Testbench for the interval counters and countdown timer.
// Assumes the host model drives the I/O port; pins made here.
`timescale 1ns/1ps
module tb_top;
	localparam int TICK = sibt_pkg::XTAL_DIV * 4;
	logic        i_clk_sys = 1'b0;
	logic        i_reset = 1'b1;
	logic        xtal = 1'b0;
	logic        bclk = 1'b0;
	logic        io_wr, io_rd, io_hit, tick, refresh, tone;
	logic [15:0] io_addr;
	logic [3:0]  io_be;
	logic [31:0] io_wdata, io_rdata;
	int          n_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	// Crystal pin at a quarter of the system rate; the filter needs two samples a level
	always #20 xtal = ~xtal;
	always #20 bclk = ~bclk;
	sibt_top dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_crystal_reference_clock(xtal), .i_expansion_bus_clock(bclk),
		.i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_addr(io_addr), .i_io_be(io_be),
		.i_io_wdata(io_wdata), .o_io_rdata(io_rdata), .o_io_hit(io_hit),
		.o_system_tick_interrupt(tick), .o_refresh_request(refresh), .o_speaker_tone(tone));
	sibt_host host_u (.i_clk_sys(i_clk_sys), .i_io_rdata(io_rdata), .i_io_hit(io_hit),
		.o_io_wr(io_wr), .o_io_rd(io_rd), .o_io_addr(io_addr), .o_io_be(io_be),
		.o_io_wdata(io_wdata));
	// ----
	// Checks and helpers
	// ----
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Countdown reads race the prescaler, so a small window is accepted
	task automatic chk_in(input string what, input logic [31:0] lo, hi, got);
		comparisons++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_errors++;
			$display("BAD %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	function automatic logic sig(input int k);
		return k == 0 ? tick : (k == 1 ? refresh : tone);
	endfunction
	task automatic wait_lvl(input int k, input logic lv, output int n);
		n = 0;
		while (sig(k) !== lv && n < 5000) begin
			@(posedge i_clk_sys);
			#2;
			n++;
		end
	endtask
	task automatic meas(input int k, output int hi, output int lo);
		int n;
		wait_lvl(k, 1'b0, n);
		wait_lvl(k, 1'b1, n);
		wait_lvl(k, 1'b0, hi);
		wait_lvl(k, 1'b1, lo);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		chk("tick idle", 32'h1, {31'h0, tick});
		chk("refresh idle", 32'h1, {31'h0, refresh});
		chk("tone idle", 32'h0, {31'h0, tone});
	endtask
	task automatic t_countdown();
		logic [31:0] d;
		logic        h;
		host_u.rd(16'h0050, d, h);
		chk("unmapped hit", 32'h0, {31'h0, h});
		host_u.rd(16'h0300, d, h);
		chk("closed hit", 32'h0, {31'h0, h});
		host_u.wr(16'h0078, 32'h0000_0301, 4'hF);
		host_u.wr(16'h0300, 32'hABCD_1234, 4'hF);
		host_u.rd(16'h0300, d, h);
		chk("open hit", 32'h1, {31'h0, h});
		chk_in("start value", 32'h1232, 32'h1234, d);
		host_u.wr(16'h0300, 32'h0000_0055, 4'hC);
		host_u.rd(16'h0300, d, h);
		chk_in("upper write", 32'h1230, 32'h1234, d);
		host_u.wr(16'h0300, 32'h0000_0100, 4'h3);
		idle(256);
		host_u.rd(16'h0300, d, h);
		chk_in("rate", 32'hF6, 32'hF8, d);
		host_u.wr(16'h0300, 32'h0000_0004, 4'h3);
		idle(200);
		host_u.rd(16'h0300, d, h);
		chk("stop at zero", 32'h0, d);
		host_u.wr(16'h0300, 32'h0000_0040, 4'hF);
		host_u.wr(16'h0078, 32'h0000_0300, 4'hF);
		idle(500);
		host_u.rd(16'h0300, d, h);
		chk("closed again", 32'h0, {31'h0, h});
		host_u.wr(16'h0078, 32'h0000_0201, 4'hF);
		host_u.rd(16'h0200, d, h);
		chk_in("ran while closed", 32'h2E, 32'h31, d);
		host_u.rd(16'h0300, d, h);
		chk("old address", 32'h0, {31'h0, h});
	endtask
	task automatic t_square();
		int hi, lo;
		host_u.wr(16'h0061, 32'h01, 4'h1);
		host_u.wr(16'h0043, 32'hB6, 4'h1);
		host_u.wr(16'h0042, 32'h04, 4'h1);
		host_u.wr(16'h0042, 32'h00, 4'h1);
		idle(6 * TICK);
		chk("speaker off", 32'h0, {31'h0, tone});
		host_u.wr(16'h0061, 32'h03, 4'h1);
		meas(2, hi, lo);
		chk("tone high", 2 * TICK, hi);
		chk("tone period", 4 * TICK, hi + lo);
		host_u.wr(16'h0043, 32'h36, 4'h1);
		host_u.wr(16'h0040, 32'h06, 4'h1);
		host_u.wr(16'h0040, 32'h00, 4'h1);
		meas(0, hi, lo);
		chk("tick high", 3 * TICK, hi);
		chk("tick period", 6 * TICK, hi + lo);
	endtask
	task automatic t_rate();
		int hi, lo;
		host_u.wr(16'h0043, 32'h74, 4'h1);
		host_u.wr(16'h0041, 32'h03, 4'h1);
		host_u.wr(16'h0041, 32'h00, 4'h1);
		meas(1, hi, lo);
		chk("refresh low", TICK, lo);
		chk("refresh period", 3 * TICK, hi + lo);
	endtask
	task automatic t_oneshot();
		int          n, lo;
		logic [31:0] d;
		logic        h;
		host_u.wr(16'h0061, 32'h02, 4'h1);
		host_u.wr(16'h0043, 32'h92, 4'h1);
		host_u.wr(16'h0042, 32'h03, 4'h1);
		host_u.wr(16'h0042, 32'h00, 4'h1);
		idle(2 * TICK);
		chk("no gate no start", 32'h1, {31'h0, tone});
		host_u.wr(16'h0061, 32'h03, 4'h1);
		wait_lvl(2, 1'b0, n);
		wait_lvl(2, 1'b1, lo);
		chk("one-shot low", 3 * TICK, lo);
		host_u.rd(16'h0061, d, h);
		chk("control readback", 32'h23, d);
		idle(4 * TICK);
		chk("no retrigger", 32'h1, {31'h0, tone});
		host_u.rd(16'h0042, d, h);
		chk("one-shot count", 32'h0, d);
	endtask
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		idle(10);
		#1;
		i_reset = 1'b0;
		idle(6);
		t_reset();
		t_countdown();
		t_square();
		t_rate();
		t_oneshot();
		results();
	end
endmodule
